// ==== common/rrce_consts.vh ====
// Constants for the return, rotate and context-switch execution block
`ifndef RRCE_CONSTS_VH
`define RRCE_CONSTS_VH
// ****************************************
// Opcode first and second bytes
// ****************************************
`define RRCE_OP_RETI0 8'hFB
`define RRCE_OP_RETI1 8'h88
`define RRCE_OP_RETURN_AND_POP 8'hEB
`define RRCE_OP_RETS0 8'hDB
`define RRCE_OP_RETS1 8'h00
`define RRCE_OP_ROLI 8'h1C
`define RRCE_OP_ROLR 8'h0C
`define RRCE_OP_RORI 8'h3C
`define RRCE_OP_RORR 8'h2C
`define RRCE_OP_BRK0 8'h8C
`define RRCE_OP_BRK1 8'h00
`define RRCE_OP_CXTI 8'hC6
`define RRCE_OP_CXTM 8'hD6
// ****************************************
// Stack step, trap vector, flag positions
// ****************************************
`define RRCE_SP_STEP 16'h0002
`define RRCE_TRAP_VEC 4'h8
`define RRCE_MOST_NEG 16'h8000
`define RRCE_ZERO16 16'h0000
`define RRCE_FE 4
`define RRCE_FZ 3
`define RRCE_FV 2
`define RRCE_FC 1
`define RRCE_FN 0
`define RRCE_FLAG_RST 5'h00
`define RRCE_SP_RST 16'hFC00
`endif

// ==== logic/rrce_rotator.v ====
// Rotate datapath: left/right rotate with carry and sticky rounding flags
`timescale 1ns/10ps
module rrce_rotator #(
  parameter W = 16
) (
  input wire [W-1:0] opnd_i, // Operand to rotate
  input wire [3:0] cnt_i, // Rotate count 0..15; a count of 15 rotates all 15 steps
  input wire right_i, // High for rotate right
  output reg [W-1:0] res_o, // Rotated result
  output reg carry_o, // Last bit rotated out
  output reg round_o // Sticky rounding flag (right only)
);
  integer k;
  reg [W-1:0] v;
  reg c;
  reg r;
  // ****************************************
  // Iterative rotate, unrolled by the tool
  // ****************************************
  always @* begin
    v = opnd_i;
    c = 1'b0;
    r = 1'b0;
    for (k = 0; k < 15; k = k + 1) begin
      if (k < cnt_i) begin
        if (right_i) begin
          r = r | c; // [RULE13]
          c = v[0];
          v = {v[0], v[W-1:1]}; // [RULE9]
        end else begin
          c = v[W-1];
          v = {v[W-2:0], v[W-1]}; // [RULE8]
        end
      end
    end
    res_o = v;
    carry_o = c; // [RULE11] [RULE12]
    round_o = r;
  end
endmodule

// ==== logic/rrce_exec.v ====
// Execution unit for returns, rotates, software break and context switch
// Operation
// [RULE1] Plain return loads pointer from stack word then adds two to stack pointer.
// [RULE2] Interrupt return pops pointer, optional segment, then status, adding two each.
// [RULE3] Segment pop and its increment happen only when segmentation is enabled.
// [RULE4] Interrupt return restores all five flags from the popped status word.
// [RULE5] Return-and-pop pops pointer, then pops next word into named register.
// [RULE6] Return-and-pop sets table-end, zero, negative from popped word; V, C kept.
// [RULE7] Inter-segment return pops pointer, segment if enabled, always adds four total.
// [RULE8] Rotate-left moves bit 15 into bit 0 and carry per step.
// [RULE9] Rotate-right moves bit 0 into bit 15 and carry per step.
// [RULE10] Counts are 0..15; register counts use only the low four bits. The rotator does all 15 steps for count 15.
// [RULE11] Rotate-left carry is last top bit out; overflow, table-end cleared.
// [RULE12] Rotate-right carry is last bit 0 out; table-end cleared.
// [RULE13] Rotate-right overflow is sticky OR of previous carries, zero for count zero.
// [RULE14] Zero flag from result zero, negative flag from result top bit.
// [RULE15] Software break enters debug mode if enabled, else trap vector 8.
// [RULE16] Context switch pushes old register value then loads second operand.
// [RULE17] Context switch leaves flags unchanged; encodings C6 and D6.
// [RULE18] Stack accesses are word accesses at stack pointer, in listed order.
`timescale 1ns/10ps
`include "rrce_consts.vh"
module rrce_exec #(
  parameter W = 16
) (
  input wire mclk_i, // Core clock
  input wire rst_i, // Async reset, active high
  input wire start_i, // Pulse: execute instruction in op bytes
  input wire [7:0] op0_i, // First opcode byte
  input wire [7:0] op1_i, // Second opcode byte
  input wire [W-1:0] reg_val_i, // Value of register named by op1 (first operand)
  input wire [W-1:0] src_val_i, // Second operand (count register, imm or mem word)
  input wire segmentation_disable_i, // Control bit: segmentation disabled
  input wire brk_en_i, // Emulator has enabled software break
  input wire [W-1:0] mem_rdata_i, // Stack read data, valid with mem_ack_i
  input wire mem_ack_i, // Stack access complete
  output reg mem_req_o, // Stack access request (word)
  output reg mem_we_o, // Stack access is a write
  output reg [W-1:0] mem_addr_o, // Stack word address
  output reg [W-1:0] mem_wdata_o, // Stack write data
  output reg [W-1:0] stack_pointer_o, // Stack pointer
  output reg [W-1:0] instruction_pointer_o, // Instruction pointer
  output reg [W-1:0] code_segment_pointer_o, // Code segment pointer
  output reg [W-1:0] processor_status_word_o, // Status word
  output reg [4:0] flags_o, // E Z V C N
  output reg reg_we_o, // Pulse: write reg_wdata_o to named register
  output reg [W-1:0] reg_wdata_o, // Register write data
  output reg brk_mode_o, // Pulse: enter debug break mode
  output reg trap_o, // Pulse: raise class A trap
  output reg [3:0] trap_vec_o, // Trap vector
  output wire busy_o, // Instruction in progress
  output reg done_o // Pulse: instruction finished
);
  localparam S_IDLE = 3'h0;
  localparam S_POPIP = 3'h1;
  localparam S_POPCS = 3'h2;
  localparam S_POPSW = 3'h3;
  localparam S_POPRG = 3'h4;
  localparam S_PUSH = 3'h5;
  localparam K_RETURN_FROM_INTERRUPT = 2'h0;
  localparam K_RETURN_AND_POP = 2'h1;
  localparam K_RETURN_INTER_SEGMENT = 2'h2;
  reg [2:0] st_q;
  reg [1:0] kind_q;
  reg [W-1:0] tmp2_q;
  reg seg_q;
  wire [W-1:0] rot_res;
  wire rot_c;
  wire rot_v;
  wire is_rol = (op0_i == `RRCE_OP_ROLI) || (op0_i == `RRCE_OP_ROLR);
  wire is_ror = (op0_i == `RRCE_OP_RORI) || (op0_i == `RRCE_OP_RORR);
  wire imm_cnt = (op0_i == `RRCE_OP_ROLI) || (op0_i == `RRCE_OP_RORI);
  // Immediate count sits in op1 upper nibble; register count uses low four bits
  wire [3:0] cnt = imm_cnt ? op1_i[7:4] : src_val_i[3:0]; // [RULE10]
  wire [W-1:0] sp_inc = stack_pointer_o + `RRCE_SP_STEP;
  wire [W-1:0] sp_dec = stack_pointer_o - `RRCE_SP_STEP;
  assign busy_o = (st_q != S_IDLE);

  // ****************************************
  // Rotate datapath
  // ****************************************
  rrce_rotator #(.W(W)) u_rot (
    .opnd_i(reg_val_i),
    .cnt_i(cnt),
    .right_i(is_ror),
    .res_o(rot_res),
    .carry_o(rot_c),
    .round_o(rot_v)
  );

  // Stack request is combinational from state so accesses follow sequence order
  always @* begin
    mem_req_o = busy_o; // [RULE18]
    mem_we_o = (st_q == S_PUSH);
    mem_addr_o = stack_pointer_o;
    mem_wdata_o = tmp2_q;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      kind_q <= K_RETURN_FROM_INTERRUPT;
      tmp2_q <= `RRCE_ZERO16;
      seg_q <= 1'b0;
      stack_pointer_o <= `RRCE_SP_RST;
      instruction_pointer_o <= `RRCE_ZERO16;
      code_segment_pointer_o <= `RRCE_ZERO16;
      processor_status_word_o <= `RRCE_ZERO16;
      flags_o <= `RRCE_FLAG_RST;
      reg_we_o <= 1'b0;
      reg_wdata_o <= `RRCE_ZERO16;
      brk_mode_o <= 1'b0;
      trap_o <= 1'b0;
      trap_vec_o <= 4'h0;
      done_o <= 1'b0;
    end else begin
      reg_we_o <= 1'b0;
      brk_mode_o <= 1'b0;
      trap_o <= 1'b0;
      done_o <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (start_i) begin
            seg_q <= ~segmentation_disable_i;
            if (op0_i == `RRCE_OP_RETI0 && op1_i == `RRCE_OP_RETI1) begin
              kind_q <= K_RETURN_FROM_INTERRUPT; // [RULE2]
              st_q <= S_POPIP;
            end else if (op0_i == `RRCE_OP_RETURN_AND_POP) begin
              kind_q <= K_RETURN_AND_POP; // [RULE5]
              st_q <= S_POPIP;
            end else if (op0_i == `RRCE_OP_RETS0 && op1_i == `RRCE_OP_RETS1) begin
              kind_q <= K_RETURN_INTER_SEGMENT; // [RULE7]
              st_q <= S_POPIP;
            end else if (is_rol || is_ror) begin
              // Single-cycle rotate; result goes back to first operand
              reg_we_o <= 1'b1;
              reg_wdata_o <= rot_res;
              done_o <= 1'b1;
              flags_o[`RRCE_FE] <= 1'b0; // [RULE11] [RULE12]
              flags_o[`RRCE_FZ] <= (rot_res == `RRCE_ZERO16); // [RULE14]
              flags_o[`RRCE_FN] <= rot_res[W-1]; // [RULE14]
              flags_o[`RRCE_FC] <= rot_c; // [RULE11] [RULE12]
              flags_o[`RRCE_FV] <= is_ror ? rot_v : 1'b0; // [RULE11] [RULE13]
            end else if (op0_i == `RRCE_OP_BRK0 && op1_i == `RRCE_OP_BRK1) begin
              // Flags untouched either way
              brk_mode_o <= brk_en_i; // [RULE15]
              trap_o <= ~brk_en_i; // [RULE15]
              trap_vec_o <= `RRCE_TRAP_VEC; // [RULE15]
              done_o <= 1'b1;
            end else if (op0_i == `RRCE_OP_CXTI || op0_i == `RRCE_OP_CXTM) begin
              // Both operands captured on the same edge the stack pointer drops; flags kept
              tmp2_q <= reg_val_i; // [RULE16]
              reg_wdata_o <= src_val_i; // [RULE16] [RULE17]
              stack_pointer_o <= sp_dec; // [RULE16]
              st_q <= S_PUSH;
            end else begin
              done_o <= 1'b1;
            end
          end
        end
        S_POPIP: if (mem_ack_i) begin
          instruction_pointer_o <= mem_rdata_i; // [RULE1]
          stack_pointer_o <= sp_inc; // [RULE1]
          if (kind_q == K_RETURN_AND_POP) begin
            st_q <= S_POPRG;
          end else if (kind_q == K_RETURN_INTER_SEGMENT) begin
            st_q <= seg_q ? S_POPCS : S_IDLE; // [RULE7]
            if (!seg_q) begin
              // Skipped segment still costs a stack word
              stack_pointer_o <= sp_inc + `RRCE_SP_STEP; // [RULE7]
              done_o <= 1'b1;
            end
          end else begin
            st_q <= seg_q ? S_POPCS : S_POPSW; // [RULE3]
          end
        end
        S_POPCS: if (mem_ack_i) begin
          code_segment_pointer_o <= mem_rdata_i; // [RULE3] [RULE7]
          stack_pointer_o <= sp_inc;
          if (kind_q == K_RETURN_INTER_SEGMENT) begin
            st_q <= S_IDLE;
            done_o <= 1'b1;
          end else begin
            st_q <= S_POPSW;
          end
        end
        S_POPSW: if (mem_ack_i) begin
          processor_status_word_o <= mem_rdata_i; // [RULE2]
          flags_o <= mem_rdata_i[`RRCE_FE:`RRCE_FN]; // [RULE4]
          stack_pointer_o <= sp_inc;
          st_q <= S_IDLE;
          done_o <= 1'b1;
        end
        S_POPRG: if (mem_ack_i) begin
          reg_we_o <= 1'b1;
          reg_wdata_o <= mem_rdata_i; // [RULE5]
          stack_pointer_o <= sp_inc; // [RULE5]
          flags_o[`RRCE_FE] <= (mem_rdata_i == `RRCE_MOST_NEG); // [RULE6]
          flags_o[`RRCE_FZ] <= (mem_rdata_i == `RRCE_ZERO16); // [RULE6]
          flags_o[`RRCE_FN] <= mem_rdata_i[W-1]; // [RULE6]
          st_q <= S_IDLE;
          done_o <= 1'b1;
        end
        S_PUSH: if (mem_ack_i) begin
          // Push finished; now load the register
          reg_we_o <= 1'b1; // [RULE16]
          st_q <= S_IDLE;
          done_o <= 1'b1;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== verification/rrce_stack_model.sv ====
// Word-wide system stack memory that answers the execution unit
`timescale 1ns/10ps
module rrce_stack_model (
  input wire mclk_i, // Core clock
  input wire rst_i, // Async reset, active high
  input wire req_i, // Word access request
  input wire we_i, // Access is a write
  input wire [15:0] addr_i, // Byte address of the word
  input wire [15:0] wdata_i, // Write data
  input wire [1:0] dly_i, // Wait cycles before each answer
  output logic [15:0] rdata_o, // Read data, valid with ack
  output logic ack_o // One-cycle completion
);
  logic [15:0] mem [0:255];
  logic [1:0] cnt;
  // Read data flips outside the ack cycle so a stale word never matches
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt <= 2'h0;
      rdata_o <= 16'hA5C3;
    end else if (!ack_o && req_i && cnt == dly_i) begin
      ack_o <= 1'b1;
      cnt <= 2'h0;
      rdata_o <= we_i ? ~rdata_o : mem[addr_i[8:1]];
      if (we_i) mem[addr_i[8:1]] <= wdata_i;
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) cnt <= cnt + 2'h1;
    end
  end
endmodule

// ==== verification/rrce_exec_sva.sv ====
// Concurrent checks on the execution unit ports
`timescale 1ns/10ps
`include "rrce_consts.vh"
module rrce_exec_sva (
  input wire mclk_i, // Core clock
  input wire rst_i, // Async reset
  input wire start_i, // Instruction start
  input wire [7:0] op0_i, // First opcode byte
  input wire [7:0] op1_i, // Second opcode byte
  input wire brk_en_i, // Break enabled
  input wire mem_ack_i, // Access done
  input wire mem_req_o, // Access request
  input wire mem_we_o, // Access is a write
  input wire [15:0] mem_addr_o, // Stack address
  input wire [15:0] stack_pointer_o, // Stack pointer
  input wire [15:0] processor_status_word_o, // Status word
  input wire [4:0] flags_o, // E Z V C N
  input wire reg_we_o, // Register write
  input wire [15:0] reg_wdata_o, // Register data
  input wire brk_mode_o, // Break mode entry
  input wire trap_o, // Trap raised
  input wire [3:0] trap_vec_o, // Trap vector
  input wire busy_o, // Busy
  input wire done_o // Done
);
  // ***********
  // Helpers
  // ***********
  logic [7:0] op_q;
  wire take = start_i && !busy_o;
  wire rot = op0_i[3:0] == 4'hC && op0_i[7:6] == 2'b00;
  wire rq = op_q[3:0] == 4'hC && op_q[7:6] == 2'b00;
  wire cxt = op0_i == `RRCE_OP_CXTI || op0_i == `RRCE_OP_CXTM;
  // Opcode in flight, so end-of-instruction checks know what ran
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) op_q <= 8'h00;
    else if (take) op_q <= op0_i;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_addr_at_sp: assert property (mem_req_o |-> mem_addr_o == stack_pointer_o)
    else $error("stack access away from stack pointer");
  a_pop_step: assert property (mem_req_o && mem_ack_i && !mem_we_o &&
    op_q != `RRCE_OP_RETS0 |=> stack_pointer_o == $past(stack_pointer_o) + `RRCE_SP_STEP)
    else $error("pop did not add two");
  a_return_from_interrupt_flags: assert property (done_o && op_q == `RRCE_OP_RETI0 |->
    flags_o == processor_status_word_o[4:0]) else $error("flags not from status word");
  a_push_dec: assert property (take && cxt |=>
    stack_pointer_o == $past(stack_pointer_o) - `RRCE_SP_STEP) else $error("push step wrong");
  a_cxt_flags: assert property (take && cxt |=> $stable(flags_o) [*2])
    else $error("context switch moved flags");
  a_rot_quick: assert property (take && rot |=> done_o && reg_we_o)
    else $error("rotate result late");
  a_rot_zn: assert property (done_o && rq |-> !flags_o[`RRCE_FE] &&
    flags_o[`RRCE_FZ] == (reg_wdata_o == 16'h0000) && flags_o[`RRCE_FN] == reg_wdata_o[15])
    else $error("rotate flags wrong");
  a_rol_vclr: assert property (done_o && rq && !op_q[5] |-> !flags_o[`RRCE_FV])
    else $error("rotate left set overflow");
  a_brk_route: assert property (take && op0_i == `RRCE_OP_BRK0 && op1_i == `RRCE_OP_BRK1 |=>
    brk_mode_o == $past(brk_en_i) && trap_o == !$past(brk_en_i)) else $error("break routed wrong");
  a_trap_vec: assert property (trap_o |-> trap_vec_o == `RRCE_TRAP_VEC)
    else $error("trap vector wrong");
  c_return_from_interrupt: cover property (take && op0_i == `RRCE_OP_RETI0);
  c_rot: cover property (take && rot);
  c_trap: cover property (trap_o);
  c_brk: cover property (brk_mode_o);
endmodule

// ==== verification/rrce_exec_bench.sv ====
// Self-checking bench for the return, rotate, break and context-switch unit
`timescale 1ns/10ps
`include "rrce_consts.vh"
module rrce_exec_bench;
  logic mclk_i = 0, rst_i = 1, start_i = 0, segmentation_disable_i = 0, brk_en_i = 0;
  logic mem_ack_i, mem_req_o, mem_we_o, reg_we_o, brk_mode_o, trap_o, busy_o, done_o;
  logic [7:0] op0_i = 0, op1_i = 0;
  logic [15:0] reg_val_i = 0, src_val_i = 0, mem_rdata_i, mem_addr_o, mem_wdata_o, reg_wdata_o;
  logic [15:0] stack_pointer_o, instruction_pointer_o, code_segment_pointer_o;
  logic [15:0] processor_status_word_o, got_w, exp_sp, exp_csp, w0, w1, w2;
  logic [4:0] flags_o, exp_fl;
  logic [3:0] trap_vec_o, k;
  logic [1:0] dly = 0;
  logic got_brk, got_trap;
  int fails = 0, samples_checked = 0, i, n;
  rrce_exec u_dut (.*);
  rrce_stack_model u_mem (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .dly_i(dly), .rdata_o(mem_rdata_i),
    .ack_o(mem_ack_i));
  always #2 mclk_i = ~mclk_i;
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Issue one instruction, gather its pulses until done; bounded so a hang still ends
  task run(input logic [7:0] a, input logic [7:0] b, input logic [15:0] r, input logic [15:0] s);
    @(posedge mclk_i);
    {op0_i, op1_i, reg_val_i, src_val_i, start_i} <= {a, b, r, s, 1'b1};
    dly <= 2'($urandom_range(3));
    {got_w, got_brk, got_trap} = {16'hXXXX, 2'b00};
    @(posedge mclk_i);
    start_i <= 1'b0;
    for (n = 0; n < 40; n++) begin
      #1;
      if (reg_we_o === 1'b1) got_w = reg_wdata_o;
      got_brk |= brk_mode_o === 1'b1;
      got_trap |= trap_o === 1'b1;
      if (done_o === 1'b1) break;
      @(posedge mclk_i);
    end
    if (n == 40) fails++;
  endtask
  // Reference rotate: returns {E,Z,V,C,N} and the result, stepped one bit at a time
  function automatic logic [20:0] rot(input bit left, input logic [15:0] v, input logic [3:0] c);
    logic cy = 0, ov = 0;
    for (int j = 0; j < c; j++) begin
      if (!left) ov = ov | cy;
      cy = left ? v[15] : v[0];
      v = left ? {v[14:0], cy} : {cy, v[15:1]};
    end
    return {1'b0, v == 16'h0, ov, cy, v[15], v};
  endfunction
  // Preload three stack words above the stack pointer
  task fill;
    {w0, w1, w2} = {16'($urandom), 16'($urandom), 16'($urandom)};
    u_mem.mem[exp_sp[8:1]] = w0;
    u_mem.mem[exp_sp[8:1] + 8'h1] = w1;
    u_mem.mem[exp_sp[8:1] + 8'h2] = w2;
  endtask
  task chk_fl;
    chk({11'h000, flags_o}, {11'h000, exp_fl});
  endtask
  initial begin
    repeat (20000) @(posedge mclk_i);
    fails++;
    report_and_stop;
  end
  // ***********
  // Main sequence
  // ***********
  initial begin
    void'($urandom(32'h1bb721ab));
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    {exp_sp, exp_csp, exp_fl} = {`RRCE_SP_RST, 16'h0000, 5'h00};
    for (i = 0; i < 48; i++) begin
      w0 = (i == 9) ? 16'h0000 : 16'($urandom);
      w1 = (i < 4) ? 16'h0000 : (i < 8) ? 16'hFFFF : 16'($urandom);
      k = i[0] ? w1[3:0] : w1[7:4];
      run({2'b00, i[1], ~i[0], 4'hC}, w1[7:0], w0, w1);
      {exp_fl, w2} = rot(!i[1], w0, k);
      chk(got_w, w2);
      chk({11'h000, flags_o}, {11'h000, exp_fl});
    end
    $display("rotate tests done");
    for (i = 0; i < 2; i++) begin
      @(posedge mclk_i);
      {segmentation_disable_i, brk_en_i} <= {i[0], i[0]};
      fill;
      run(`RRCE_OP_RETI0, `RRCE_OP_RETI1, 16'h0, 16'h0);
      chk(instruction_pointer_o, w0);
      if (!i[0]) exp_csp = w1;
      chk(code_segment_pointer_o, exp_csp);
      w2 = i[0] ? w1 : w2;
      exp_sp += i[0] ? 16'h4 : 16'h6;
      chk(stack_pointer_o, exp_sp);
      chk(processor_status_word_o, w2);
      exp_fl = w2[4:0];
      chk({11'h000, flags_o}, {11'h000, exp_fl});
      fill;
      run(`RRCE_OP_RETS0, `RRCE_OP_RETS1, 16'h0, 16'h0);
      chk(instruction_pointer_o, w0);
      if (!i[0]) exp_csp = w1;
      chk(code_segment_pointer_o, exp_csp);
      exp_sp += 16'h4;
      chk(stack_pointer_o, exp_sp);
      chk_fl;
      fill;
      w1 = i[0] ? 16'h0000 : `RRCE_MOST_NEG;
      u_mem.mem[exp_sp[8:1] + 8'h1] = w1;
      run(`RRCE_OP_RETURN_AND_POP, 8'h12, 16'h0, 16'h0);
      chk(instruction_pointer_o, w0);
      chk(got_w, w1);
      exp_sp += 16'h4;
      chk(stack_pointer_o, exp_sp);
      exp_fl = {w1 == `RRCE_MOST_NEG, w1 == 16'h0, exp_fl[2:1], w1[15]};
      chk({11'h000, flags_o}, {11'h000, exp_fl});
      {w0, w1} = $urandom;
      run(i[0] ? `RRCE_OP_CXTM : `RRCE_OP_CXTI, 8'h12, w0, w1);
      exp_sp -= 16'h2;
      chk(stack_pointer_o, exp_sp);
      chk(u_mem.mem[exp_sp[8:1]], w0);
      chk(got_w, w1);
      chk_fl;
      run(`RRCE_OP_BRK0, `RRCE_OP_BRK1, 16'h0, 16'h0);
      chk({14'h0, got_brk, got_trap}, {14'h0, i[0], ~i[0]});
      if (!i[0]) chk({12'h0, trap_vec_o}, {12'h0, `RRCE_TRAP_VEC});
      chk_fl;
    end
    $display("stack tests done");
    report_and_stop;
  end
endmodule
bind rrce_exec rrce_exec_sva u_sva (.*);
